// ==== src/pport_pkg.sv ====
// Shared constants for the byte port and its parallel slave
package pport_pkg;
    // ------------------------------------------------------------------
    // Register indices on the core register port
    // ------------------------------------------------------------------
    localparam logic [2:0] REG_BYTE_VALUE   = 3'h0;
    localparam logic [2:0] REG_BYTE_LATCH   = 3'h1;
    localparam logic [2:0] REG_BYTE_DIR     = 3'h2;
    localparam logic [2:0] REG_CTRL_VALUE   = 3'h3;
    localparam logic [2:0] REG_CTRL_LATCH   = 3'h4;
    localparam logic [2:0] REG_CTRL_DIR     = 3'h5;
    localparam logic [2:0] REG_CONV_CONFIG  = 3'h6;
    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int BIT_IN_FULL   = 7;
    localparam int BIT_OUT_FULL  = 6;
    localparam int BIT_IN_OVF    = 5;
    localparam int BIT_SLV_MODE  = 4;
    localparam logic [7:0] BYTE_DIR_RESET = 8'hFF;
    localparam logic [2:0] CTRL_DIR_RESET = 3'h7;
    localparam logic [2:0] PCFG_RESET     = 3'h0;
    localparam logic [2:0] PCFG_DIGITAL   = 3'h7;
    localparam int FIFO_DEPTH = 32;
    localparam int DATA_W     = 8;
    // Last count of the master's strobe hold and release phases; each lasts one cycle more
    localparam logic [2:0] HOLD_CYC = 3'h6;
endpackage

// ==== src/pport_if.sv ====
// Pin-level carrier between the device and the external master
`timescale 1ns/100ps
interface pport_if;
    logic [7:0] dev_d_o;
    logic [7:0] dev_d_oe;
    logic [7:0] mst_d_o;
    logic       mst_d_oe;
    logic [2:0] dev_c_o;
    logic [2:0] dev_c_oe;
    logic [2:0] mst_c_o;
    logic       mst_c_oe;
    logic [7:0] d_pin;
    logic [2:0] c_pin;
    // Resolve each wire from the enables; undriven bits float high
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            d_pin[i] = dev_d_oe[i] ? dev_d_o[i]
                     : (mst_d_oe ? mst_d_o[i] : 1'b1);
        end
        for (int j = 0; j < 3; j++) begin
            c_pin[j] = dev_c_oe[j] ? dev_c_o[j]
                     : (mst_c_oe ? mst_c_o[j] : 1'b1);
        end
    end
    modport device (output dev_d_o, dev_d_oe, dev_c_o, dev_c_oe,
                    input d_pin, c_pin);
    modport master (output mst_d_o, mst_d_oe, mst_c_o, mst_c_oe,
                    input d_pin);
endinterface // pport_if

// ==== src/pport_fifo.sv ====
// Parameterised valid/ready FIFO
`timescale 1ns/100ps
module pport_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // pport_fifo

// ==== src/pport_master.sv ====
// External 8-bit master driving the slave port strobes
`timescale 1ns/100ps
module pport_master
    import pport_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       req_valid,
    output logic            req_ready,
    input  wire logic       req_write,
    input  wire logic [7:0] req_data,
    output logic            rsp_valid,
    output logic      [7:0] rsp_data,
    pport_if.master         bus
);
    typedef enum logic [1:0] {M_IDLE, M_ASSERT, M_HOLD, M_RELEASE} mst_e;
    // ------------------------------------------------------------------
    // Strobe sequencer: hold long enough for the device synchroniser
    // ------------------------------------------------------------------
    mst_e       st_q;
    logic [2:0] cnt_q;
    logic       wr_q;
    logic [7:0] dat_q;
    logic [7:0] d1_q;
    logic [7:0] d2_q;
    logic [7:0] d3_q;

    assign req_ready = (st_q == M_IDLE);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q      <= M_IDLE;
            cnt_q     <= '0;
            wr_q      <= 1'b0;
            dat_q     <= 8'h00;
            rsp_valid <= 1'b0;
            rsp_data  <= 8'h00;
        end else begin
            rsp_valid <= 1'b0;
            case (st_q)
                M_IDLE: begin
                    if (req_valid) begin
                        wr_q  <= req_write;
                        dat_q <= req_data;
                        cnt_q <= '0;
                        st_q  <= M_ASSERT;
                    end
                end
                M_ASSERT: begin
                    st_q <= M_HOLD;
                end
                M_HOLD: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == HOLD_CYC) begin
                        cnt_q <= '0;
                        st_q  <= M_RELEASE;
                    end
                end
                default: begin
                    cnt_q <= cnt_q + 1'b1;
                    // Synchroniser lags the pins: take data after the
                    // strobe rises, while the device still drives
                    if (cnt_q == '0) begin
                        rsp_data  <= d3_q;
                        rsp_valid <= !wr_q;
                    end
                    if (cnt_q == HOLD_CYC) begin
                        st_q <= M_IDLE;
                    end
                end
            endcase
        end
    end

    // Data pins come from the device's domain: three flops before use
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            d1_q <= 8'hFF;
            d2_q <= 8'hFF;
            d3_q <= 8'hFF;
        end else begin
            d1_q <= bus.d_pin;
            d2_q <= d1_q;
            d3_q <= d2_q;
        end
    end

    // Chip select and one strobe fall together
    always_comb begin
        bus.mst_c_oe = 1'b1;
        bus.mst_c_o  = 3'h7;
        if (st_q == M_ASSERT || st_q == M_HOLD) begin
            bus.mst_c_o = wr_q ? 3'b001 : 3'b010;
        end
    end
    assign bus.mst_d_o  = dat_q;
    assign bus.mst_d_oe = wr_q && (st_q != M_IDLE);
endmodule // pport_master

// ==== src/pport_device.sv ====
// Byte port, control port and parallel slave port of the device
// ----------------------------------------------------------------------
// Function
// - Direction one makes byte pin input
// - Direction zero drives byte latch out
// - Byte latch register reads latch, not pins
// - Byte direction resets to all ones
// - Three control pins, same direction encoding
// - Control latch register reads latched values
// - Analog control pins read as zero
// - Software keeps analog pins as inputs
// - Control pins come up analog after reset
// - Direction bit 4 selects slave port mode
// - Bit 6 set until master reads byte
// - Software sets control directions before slave use
// - Software configures control pins digital first
// - Pins 0,1,2 are read, write, select
// - Write captured when select and write low
// - Read drives latch when select, read low
// - Master accesses one latch asynchronously
// - Value write updates latch, read gives pins
// ----------------------------------------------------------------------
`timescale 1ns/100ps
module pport_device
    import pport_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            rx_valid,
    input  wire logic       rx_ready,
    output logic      [7:0] rx_data,
    output logic            slave_port_event_flag,
    pport_if.device         bus
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] byte_latch_q;
    logic [7:0] byte_dir_q;
    logic [2:0] ctrl_latch_q;
    logic [2:0] ctrl_dir_q;
    logic [2:0] pcfg_q;
    logic       mode_q;
    logic       in_full_q;
    logic       out_full_q;
    logic       in_ovf_q;
    logic [7:0] d_s1_q;
    logic [7:0] d_s2_q;
    logic [7:0] d_s3_q;
    logic [7:0] d_stable_q;
    logic [2:0] c_s1_q;
    logic [2:0] c_s2_q;
    logic [2:0] c_s3_q;
    logic       wr_act_q;
    logic       rd_act_q;
    logic       ext_wr_start;
    logic       ext_rd_start;
    logic       ext_wr_end;
    logic       ext_rd_end;
    logic       core_val_rd;
    logic       core_val_wr;
    logic [2:0] c_now;
    logic       ctrl_digital;

    function automatic logic [7:0] pad3(input logic [2:0] v);
        return {5'h00, v};
    endfunction

    assign ctrl_digital = (pcfg_q == PCFG_DIGITAL);
    assign core_val_rd  = reg_rd && (reg_addr == REG_BYTE_VALUE);
    assign core_val_wr  = reg_wr && (reg_addr == REG_BYTE_VALUE);

    // ------------------------------------------------------------------
    // Pin synchronisers; a change counts when stages two and three agree
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            d_s1_q <= 8'h00;
            d_s2_q <= 8'h00;
            d_s3_q <= 8'h00;
            c_s1_q <= 3'h7;
            c_s2_q <= 3'h7;
            c_s3_q <= 3'h7;
        end else begin
            d_s1_q <= bus.d_pin;
            d_s2_q <= d_s1_q;
            d_s3_q <= d_s2_q;
            c_s1_q <= bus.c_pin;
            c_s2_q <= c_s1_q;
            c_s3_q <= c_s2_q;
        end
    end

    // Stable pin levels: a bit only moves when the two late stages agree
    logic [2:0] c_stable_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            c_stable_q <= 3'h7;
            d_stable_q <= 8'h00;
        end else begin
            for (int j = 0; j < 8; j++) begin
                if (d_s2_q[j] == d_s3_q[j]) begin
                    d_stable_q[j] <= d_s3_q[j];
                end
            end
            for (int i = 0; i < 3; i++) begin
                if (c_s2_q[i] == c_s3_q[i]) begin
                    c_stable_q[i] <= c_s3_q[i];
                end
            end
        end
    end
    assign c_now = c_stable_q;

    // Pin 0 read, pin 1 write, pin 2 select, all active low
    assign ext_wr_start = mode_q && !c_now[2] && !c_now[1] && !wr_act_q;
    assign ext_rd_start = mode_q && !c_now[2] && !c_now[0] && !rd_act_q;
    assign ext_wr_end   = wr_act_q && (c_now[2] || c_now[1]);
    assign ext_rd_end   = rd_act_q && (c_now[2] || c_now[0]);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_act_q <= 1'b0;
            rd_act_q <= 1'b0;
        end else begin
            if (ext_wr_start) begin
                wr_act_q <= 1'b1;
            end else if (ext_wr_end) begin
                wr_act_q <= 1'b0;
            end
            if (ext_rd_start) begin
                rd_act_q <= 1'b1;
            end else if (ext_rd_end) begin
                rd_act_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            byte_latch_q <= 8'h00;
        end else if (ext_wr_start) begin
            byte_latch_q <= d_stable_q;
        end else if (reg_wr && (reg_addr == REG_BYTE_VALUE ||
                                reg_addr == REG_BYTE_LATCH)) begin
            byte_latch_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            byte_dir_q   <= BYTE_DIR_RESET;
            ctrl_dir_q   <= CTRL_DIR_RESET;
            ctrl_latch_q <= 3'h0;
            mode_q       <= 1'b0;
            pcfg_q       <= PCFG_RESET;
        end else if (reg_wr) begin
            if (reg_addr == REG_BYTE_DIR) begin
                byte_dir_q <= reg_wdata;
            end else if (reg_addr == REG_CTRL_DIR) begin
                ctrl_dir_q <= reg_wdata[2:0];
                mode_q     <= reg_wdata[BIT_SLV_MODE];
            end else if (reg_addr == REG_CTRL_LATCH ||
                         reg_addr == REG_CTRL_VALUE) begin
                ctrl_latch_q <= reg_wdata[2:0];
            end else if (reg_addr == REG_CONV_CONFIG) begin
                pcfg_q <= reg_wdata[2:0];
            end
        end
    end

    // Flags: hardware set wins over a same-cycle clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            in_full_q  <= 1'b0;
            out_full_q <= 1'b0;
            in_ovf_q   <= 1'b0;
        end else begin
            if (ext_wr_start) begin
                in_full_q <= 1'b1;
            end else if (core_val_rd) begin
                in_full_q <= 1'b0;
            end
            if (core_val_wr) begin
                out_full_q <= 1'b1;
            end else if (ext_rd_end) begin
                out_full_q <= 1'b0;
            end
            if (ext_wr_start && in_full_q) begin
                in_ovf_q <= 1'b1;
            end else if (reg_wr && reg_addr == REG_CTRL_DIR &&
                         !reg_wdata[BIT_IN_OVF]) begin
                in_ovf_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            slave_port_event_flag <= 1'b0;
        end else begin
            slave_port_event_flag <= ext_wr_end || ext_rd_end;
        end
    end

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    always_comb begin
        reg_rdata = 8'h00;
        if (reg_addr == REG_BYTE_VALUE) begin
            reg_rdata = d_stable_q;
        end else if (reg_addr == REG_BYTE_LATCH) begin
            reg_rdata = byte_latch_q;
        end else if (reg_addr == REG_BYTE_DIR) begin
            reg_rdata = byte_dir_q;
        end else if (reg_addr == REG_CTRL_VALUE) begin
            reg_rdata = ctrl_digital ? pad3(c_now) : 8'h00;
        end else if (reg_addr == REG_CTRL_LATCH) begin
            reg_rdata = pad3(ctrl_latch_q);
        end else if (reg_addr == REG_CTRL_DIR) begin
            reg_rdata = {in_full_q, out_full_q, in_ovf_q, mode_q,
                         1'b0, ctrl_dir_q};
        end else if (reg_addr == REG_CONV_CONFIG) begin
            reg_rdata = pad3(pcfg_q);
        end
    end

    // ------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------
    // In slave mode the master only sees the latch during its read
    assign bus.dev_d_o  = byte_latch_q;
    assign bus.dev_d_oe = mode_q ? {8{rd_act_q}}
                                 : ~byte_dir_q;
    assign bus.dev_c_o  = ctrl_latch_q;
    // Strobes are always inputs in slave mode, whatever software set
    assign bus.dev_c_oe = mode_q ? 3'h0 : ~ctrl_dir_q;

    // Received bytes also stream to the user side; stalls drop nothing
    // the register view holds, only the stream copy is refused when full
    pport_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) pport_fifo_inst (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (ext_wr_start),
        .in_ready  (),
        .in_data   (d_stable_q),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );
endmodule // pport_device

// ==== bench/pport_properties.sv ====
// Pin-level properties of the slave port, watched on the carrier
`timescale 1ns/100ps
module pport_props_chk (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic [7:0] dev_d_oe,
    input wire logic       mst_d_oe,
    input wire logic [2:0] mst_c_o,
    input wire logic [2:0] dev_c_oe,
    input wire logic [7:0] d_pin
);
    // ------------------------------------------------------------------
    // Clocking
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // ------------------------------------------------------------------
    // Strobe framing by the master
    // ------------------------------------------------------------------
    a_select_hold: assert property (
        $fell(mst_c_o[2]) |-> !mst_c_o[2] [*7])
        else $error("select released early");
    a_select_gap: assert property (
        $rose(mst_c_o[2]) |-> mst_c_o[2] [*7])
        else $error("select reasserted too soon");
    a_strobe_pair: assert property (
        $fell(mst_c_o[2]) |->
            (mst_c_o[1:0] == 2'b01 || mst_c_o[1:0] == 2'b10))
        else $error("select fell without exactly one strobe");
    a_write_data: assert property (
        (!mst_c_o[2] && !mst_c_o[1]) |-> mst_d_oe)
        else $error("master not driving data in write");
    a_read_idle: assert property (
        !mst_c_o[0] |-> !mst_d_oe)
        else $error("master drives data in read");
    // ------------------------------------------------------------------
    // Device response; a short delay range absorbs the input sync
    // ------------------------------------------------------------------
    a_write_quiet: assert property (
        (!mst_c_o[2] && !mst_c_o[1]) |-> dev_d_oe == 8'h00)
        else $error("device drives pins during write");
    a_read_drive: assert property (
        $fell(mst_c_o[0]) |-> ##[3:6] dev_d_oe == 8'hFF)
        else $error("device did not drive read data");
    a_read_release: assert property (
        $rose(mst_c_o[0]) |-> ##[3:6] dev_d_oe == 8'h00)
        else $error("device kept driving after read");
    a_read_stable: assert property (
        $rose(dev_d_oe[0]) |=> $stable(d_pin) [*3])
        else $error("read data changed while driven");
    a_ctrl_inputs: assert property (
        !mst_c_o[2] |-> dev_c_oe == 3'h0)
        else $error("control pin driven during access");
endmodule // pport_props_chk

// ==== bench/tb_byte_port_with_parallel_slave.sv ====
// Self-checking bench: device and master joined on the pin carrier
`timescale 1ns/100ps
module tb_byte_port_with_parallel_slave;
    import pport_pkg::*;
    logic       clk, nrst, reg_wr, reg_rd, rx_ready, rx_valid;
    logic       req_valid, req_ready, req_write, rsp_valid, ev_pulse;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rx_data, req_data, rsp_data;
    int         n_errors, n_compared, n_events;
    // ------------------------------------------------------------------
    // Structure
    // ------------------------------------------------------------------
    pport_if pport_if_inst ();
    pport_device pport_device_inst (.clk(clk), .nrst(nrst),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
        .slave_port_event_flag(ev_pulse), .bus(pport_if_inst));
    pport_master pport_master_inst (.clk(clk), .nrst(nrst),
        .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_data(req_data),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .bus(pport_if_inst));
    pport_props_chk pport_checker_inst (.clk(clk), .nrst(nrst),
        .dev_d_oe(pport_if_inst.dev_d_oe),
        .mst_d_oe(pport_if_inst.mst_d_oe),
        .mst_c_o(pport_if_inst.mst_c_o),
        .dev_c_oe(pport_if_inst.dev_c_oe), .d_pin(pport_if_inst.d_pin));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (ev_pulse === 1'b1) n_events <= n_events + 1;
    end
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("errors %0d, compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic reg_put(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk); #2;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk); #2;
        reg_wr = 1'b0;
    endtask
    // Read data is combinational, so it is sampled late in the cycle
    task automatic reg_chk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk); #2;
        reg_addr = a;
        reg_rd = 1'b1;
        #18;
        check(reg_rdata, exp);
        @(posedge clk); #2;
        reg_rd = 1'b0;
    endtask
    task automatic mst_op(input logic wr, input logic [7:0] d,
                          output logic [7:0] q);
        int k;
        q = 8'h00;
        @(posedge clk); #2;
        req_valid = 1'b1;
        req_write = wr;
        req_data = d;
        for (k = 0; k < 40 && req_ready !== 1'b1; k++) @(posedge clk);
        if (k == 40) begin
            n_errors++;
            wrap_up();
        end
        @(posedge clk); #2;
        req_valid = 1'b0;
        for (k = 0; k < 60; k++) begin
            @(posedge clk); #2;
            if (rsp_valid === 1'b1) q = rsp_data;
            if (req_ready === 1'b1) break;
        end
        if (k == 60) begin
            n_errors++;
            wrap_up();
        end
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic reset_values();
        reg_chk(REG_BYTE_DIR, 8'hFF);
        reg_chk(REG_CTRL_DIR, 8'h07);
        reg_chk(REG_CTRL_VALUE, 8'h00);
        reg_chk(3'h7, 8'h00);
        check(pport_if_inst.dev_d_oe, 8'h00);
    endtask
    task automatic gpio_byte();
        reg_put(REG_BYTE_LATCH, 8'h5A);
        reg_put(REG_BYTE_DIR, 8'h0F);
        check(pport_if_inst.dev_d_oe, 8'hF0);
        repeat (5) @(posedge clk);
        check(pport_if_inst.d_pin, 8'h5F);
        reg_chk(REG_BYTE_VALUE, 8'h5F);
        reg_chk(REG_BYTE_LATCH, 8'h5A);
        reg_put(REG_BYTE_DIR, 8'hFF);
        reg_put(REG_BYTE_VALUE, 8'hC3);
        reg_chk(REG_BYTE_LATCH, 8'hC3);
        reg_chk(REG_CTRL_DIR, 8'h47);
    endtask
    task automatic gpio_ctrl();
        reg_put(REG_CTRL_LATCH, 8'h05);
        reg_put(REG_CONV_CONFIG, {5'h00, PCFG_DIGITAL});
        reg_put(REG_CTRL_DIR, 8'h00);
        check({5'h00, pport_if_inst.dev_c_oe}, 8'h07);
        reg_chk(REG_CTRL_LATCH, 8'h05);
        repeat (5) @(posedge clk);
        reg_chk(REG_CTRL_VALUE, 8'h05);
        reg_put(REG_CTRL_DIR, 8'h07);
        reg_put(REG_CONV_CONFIG, 8'h00);
        repeat (5) @(posedge clk);
        reg_chk(REG_CTRL_VALUE, 8'h00);
    endtask
    task automatic slave_write_read();
        logic [7:0] q;
        int         ev;
        reg_put(REG_CONV_CONFIG, {5'h00, PCFG_DIGITAL});
        reg_put(REG_CTRL_DIR, 8'h17);
        ev = n_events;
        mst_op(1'b1, 8'hA5, q);
        check(8'(n_events - ev), 8'h01);
        reg_chk(REG_CTRL_DIR, 8'hD7);
        check({7'h00, rx_valid}, 8'h01);
        check(rx_data, 8'hA5);
        rx_ready = 1'b1;
        @(posedge clk); #2;
        rx_ready = 1'b0;
        reg_chk(REG_BYTE_VALUE, 8'hFF);
        reg_chk(REG_CTRL_DIR, 8'h57);
        reg_put(REG_BYTE_VALUE, 8'h3C);
        reg_chk(REG_CTRL_DIR, 8'h57);
        mst_op(1'b0, 8'h00, q);
        check(q, 8'h3C);
        check(8'(n_events - ev), 8'h02);
        reg_chk(REG_CTRL_DIR, 8'h17);
    endtask
    // Master keeps writing with the stream stalled; FIFO drops the spare
    task automatic overflow_fill();
        logic [7:0] q;
        for (int i = 0; i < 33; i++) mst_op(1'b1, 8'(i), q);
        reg_chk(REG_CTRL_DIR, 8'hB7);
        reg_put(REG_CTRL_DIR, 8'h17);
        reg_chk(REG_CTRL_DIR, 8'h97);
        rx_ready = 1'b1;
        for (int i = 0; i < 32; i++) begin
            check(rx_data, 8'(i));
            @(posedge clk); #2;
        end
        rx_ready = 1'b0;
        check({7'h00, rx_valid}, 8'h00);
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        rx_ready = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_data = 8'h00;
        n_errors = 0;
        n_compared = 0;
        n_events = 0;
        repeat (3) @(posedge clk);
        #2 nrst = 1'b1;
        reset_values();
        gpio_byte();
        gpio_ctrl();
        slave_write_read();
        overflow_fill();
        wrap_up();
    end
endmodule // tb_byte_port_with_parallel_slave
